// ===== src/rf_poll_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef RF_POLL_MAP_SVH
`define RF_POLL_MAP_SVH

`define RF_MODSLEEP_ADDR 4'h3
`define RF_CHKLIM_ADDR 4'h4

`define RF_MODSLEEP_RST 8'h28
`define RF_CHKLIM_RST 8'h50

`define RF_MODSEL_BIT 7
`define RF_SLEEP_MSB 6
`define RF_SLEEP_LSB 2
`define RF_SLEEPX_BIT 1
`define RF_LIMX_BIT 0
`define RF_CHK_MSB 7
`define RF_CHK_LSB 6
`define RF_LIM_MSB 5
`define RF_LIM_LSB 0

`define RF_SLEEP_UNIT 32'h00000400
`define RF_SLEEP_XMUL 20'h8
`define RF_CHK_STEP 4'h3
`define RF_RANGE0_MUL 8'h8
`define RF_DCLK_DIV 8'h10

`endif

// ===== src/rf_poll_pkg.sv
// state types of the polling timing configuration block
package rf_poll_pkg;

  typedef enum logic [1:0] {
    SLEEP_IDLE = 2'b01,
    SLEEP_RUN = 2'b10
  } sleep_state_type;

  typedef struct packed {
    logic [7:0] modSleep;
    logic [7:0] chkLim;
    sleep_state_type sleepState;
    logic sleepDone;
    logic [19:0] sleepCnt;
    logic [19:0] sleepTarget;
    logic [6:0] edgeCnt;
    logic edgeShort;
    logic edgeOk;
    logic txPhase;
    logic [7:0] rdData;
    logic rdValid;
  } cfg_state_type;

  typedef struct packed {
    logic [7:0] cnt;
  } tick_state_type;

endpackage

// ===== src/tick_divider.sv
// programmable divider turning enable pulses into a slower tick
`timescale 1ns/100ps
module tick_divider
  import rf_poll_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // control
  input wire logic en,
  input wire logic clear,
  input wire logic [7:0] period,
  // output
  output logic tick
);

  tick_state_type st_r;
  tick_state_type st_nxt;

  // period zero behaves as period one
  assign tick = en && !clear && (({1'b0, st_r.cnt} + 9'h001) >= {1'b0, period});

  always_comb begin
    st_nxt = st_r;
    if (clear || tick) begin
      st_nxt.cnt = 8'h00;
    end else if (en) begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r <= '{cnt: 8'h00};
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// ===== src/rf_poll_timing_config.sv
// modulation, sleep and bit-check timing configuration with its timers
`timescale 1ns/100ps
`include "rf_poll_map.svh"
module rf_poll_timing_config
  import rf_poll_pkg::*;
#(
  parameter int SLEEP_UNIT = `RF_SLEEP_UNIT,
  parameter logic [7:0] DCLK_DIV = `RF_DCLK_DIV
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [3:0] addr,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData,
  output logic rdValid,
  // protocol side inputs
  input wire logic txMode,
  input wire logic [1:0] bitRateRange,
  input wire logic sleepStart,
  input wire logic edgeIn,
  // configuration outputs
  output logic modulation_select,
  output logic [3:0] check_bit_count,
  output logic [5:0] limitMin,
  // timing outputs
  output logic sleepBusy,
  output logic sleepDone,
  output logic dclkTick,
  output logic xdclkTick,
  output logic edgeShort,
  output logic edgeOk,
  output logic txHalfTick,
  output logic txBitTick
);

  cfg_state_type st_r;
  cfg_state_type st_nxt;
  logic [7:0] rangeMul;
  logic [7:0] prescale;
  logic [7:0] halfPeriod;
  logic [19:0] sleepTargetNew;

  //////////////////////////////////////////////////////////////////////////////
  // field decode
  assign modulation_select = st_r.modSleep[`RF_MODSEL_BIT];
  assign check_bit_count = `RF_CHK_STEP * {2'b00, st_r.chkLim[`RF_CHK_MSB:`RF_CHK_LSB]};
  // values below ten are stored as written
  assign limitMin = st_r.chkLim[`RF_LIM_MSB:`RF_LIM_LSB];
  assign rangeMul = `RF_RANGE0_MUL >> bitRateRange;
  assign prescale = st_r.modSleep[`RF_LIMX_BIT] ? (rangeMul << 1) : rangeMul;
  assign halfPeriod = {2'b00, limitMin} + 8'h01;
  assign sleepTargetNew = 20'({15'h0000, st_r.modSleep[`RF_SLEEP_MSB:`RF_SLEEP_LSB]}
    * 20'(SLEEP_UNIT)
    * (st_r.modSleep[`RF_SLEEPX_BIT] ? `RF_SLEEP_XMUL : 20'h1));

  assign sleepBusy = (st_r.sleepState == SLEEP_RUN);
  assign sleepDone = st_r.sleepDone;
  assign edgeShort = st_r.edgeShort;
  assign edgeOk = st_r.edgeOk;
  assign rdData = st_r.rdData;
  assign rdValid = st_r.rdValid;
  assign txBitTick = txHalfTick && st_r.txPhase;

  //////////////////////////////////////////////////////////////////////////////
  // dividers
  tick_divider baseDiv (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .en(1'b1),
    .clear(1'b0),
    .period(DCLK_DIV),
    .tick(dclkTick)
  );

  tick_divider scaledDiv (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .en(dclkTick),
    .clear(wrEn),
    .period(prescale),
    .tick(xdclkTick)
  );

  tick_divider halfBitDiv (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .en(xdclkTick && txMode),
    .clear(!txMode || wrEn),
    .period(halfPeriod),
    .tick(txHalfTick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.sleepDone = 1'b0;
    st_nxt.edgeShort = 1'b0;
    st_nxt.edgeOk = 1'b0;
    st_nxt.rdValid = 1'b0;
    if (wrEn && addr == `RF_MODSLEEP_ADDR) begin
      st_nxt.modSleep = wrData;
    end else if (wrEn && addr == `RF_CHKLIM_ADDR) begin
      st_nxt.chkLim = wrData;
    end
    if (rdEn) begin
      st_nxt.rdValid = 1'b1;
      if (addr == `RF_MODSLEEP_ADDR) begin
        st_nxt.rdData = st_r.modSleep;
      end else if (addr == `RF_CHKLIM_ADDR) begin
        st_nxt.rdData = st_r.chkLim;
      end else begin
        st_nxt.rdData = 8'h00;
      end
    end
    case (st_r.sleepState)
      SLEEP_IDLE: begin
        if (sleepStart) begin
          st_nxt.sleepCnt = 20'h00000;
          st_nxt.sleepTarget = sleepTargetNew;
          if (sleepTargetNew == 20'h00000) begin
            st_nxt.sleepDone = 1'b1;
          end else begin
            st_nxt.sleepState = SLEEP_RUN;
          end
        end
      end
      SLEEP_RUN: begin
        if (dclkTick) begin
          st_nxt.sleepCnt = st_r.sleepCnt + 20'h00001;
          if (st_r.sleepCnt + 20'h00001 == st_r.sleepTarget) begin
            st_nxt.sleepDone = 1'b1;
            st_nxt.sleepState = SLEEP_IDLE;
          end
        end
      end
      default: begin
        st_nxt.sleepState = SLEEP_IDLE;
      end
    endcase
    if (txMode) begin
      st_nxt.edgeCnt = 7'h00;
    end else if (edgeIn) begin
      st_nxt.edgeCnt = 7'h00;
      st_nxt.edgeShort = (st_r.edgeCnt < {1'b0, limitMin});
      st_nxt.edgeOk = !(st_r.edgeCnt < {1'b0, limitMin});
    end else if (xdclkTick && st_r.edgeCnt != 7'h7f) begin
      st_nxt.edgeCnt = st_r.edgeCnt + 7'h01;
    end
    if (!txMode || wrEn) begin
      st_nxt.txPhase = 1'b0;
    end else if (txHalfTick) begin
      st_nxt.txPhase = !st_r.txPhase;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r <= '{modSleep: `RF_MODSLEEP_RST, chkLim: `RF_CHKLIM_RST,
        sleepState: SLEEP_IDLE, sleepDone: 1'b0, sleepCnt: 20'h00000,
        sleepTarget: 20'h00000, edgeCnt: 7'h00, edgeShort: 1'b0, edgeOk: 1'b0,
        txPhase: 1'b0, rdData: 8'h00, rdValid: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  logic [19:0] busyTicks;
  logic [7:0] dclkSince;
  logic [7:0] xdSince;
  logic [6:0] edgeSince;

  always_ff @(posedge sys_clk) begin
    if (!rst_n || sleepStart) begin
      busyTicks <= 20'h00000;
    end else if (sleepBusy && dclkTick) begin
      busyTicks <= busyTicks + 20'h00001;
    end
    if (!rst_n || wrEn || xdclkTick) begin
      dclkSince <= 8'h00;
    end else if (dclkTick) begin
      dclkSince <= dclkSince + 8'h01;
    end
    if (!rst_n || wrEn || !txMode || txBitTick) begin
      xdSince <= 8'h00;
    end else if (xdclkTick) begin
      xdSince <= xdSince + 8'h01;
    end
    if (!rst_n || txMode || edgeIn) begin
      edgeSince <= 7'h00;
    end else if (xdclkTick && edgeSince != 7'h7f) begin
      edgeSince <= edgeSince + 7'h01;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  chk_modsel_write: assert property (
    wrEn && addr == `RF_MODSLEEP_ADDR |=> modulation_select == $past(wrData[7]))
    else $error("modulation select did not follow write");
  chk_sleep_zero: assert property (
    !sleepBusy && sleepStart && st_r.modSleep[`RF_SLEEP_MSB:`RF_SLEEP_LSB] == 5'h00
      |=> sleepDone && !sleepBusy)
    else $error("zero sleep did not end at once");
  chk_sleep_length: assert property (
    sleepBusy && sleepDone == 1'b0 ##1 sleepDone |-> busyTicks == st_r.sleepTarget)
    else $error("sleep length differs from programmed count");
  chk_sleep_target: assert property (
    !sleepBusy && sleepStart && st_r.modSleep[`RF_SLEEP_MSB:`RF_SLEEP_LSB] != 5'h00
      |=> sleepBusy
      && st_r.sleepTarget == 20'($past(st_r.modSleep[`RF_SLEEP_MSB:`RF_SLEEP_LSB]))
        * 20'(SLEEP_UNIT) * ($past(st_r.modSleep[`RF_SLEEPX_BIT]) ? 20'h8 : 20'h1))
    else $error("sleep not started with target");
  chk_check_bits: assert property (
    wrEn && addr == `RF_CHKLIM_ADDR |=> check_bit_count == 4'(3 * $past(wrData[7:6])))
    else $error("check bit count wrong");
  chk_scaled_period: assert property (
    xdclkTick |-> dclkSince + 8'h01 == prescale)
    else $error("scaled period wrong");
  chk_edge_short: assert property (
    edgeIn && !txMode && edgeSince < {1'b0, limitMin} |=> edgeShort && !edgeOk)
    else $error("short edge not flagged");
  chk_edge_ok: assert property (
    edgeIn && !txMode && edgeSince >= {1'b0, limitMin} |=> edgeOk && !edgeShort)
    else $error("valid edge not accepted");
  chk_tx_bitrate: assert property (
    txBitTick |-> xdSince + 8'h01 == {limitMin, 1'b0} + 8'h02)
    else $error("tx bit period wrong");

  cov_sleep_done: cover property (sleepBusy ##1 sleepDone);
  cov_edge_short: cover property (edgeShort);
  cov_edge_ok: cover property (edgeOk);
  cov_tx_bit: cover property (txBitTick);

endmodule

// ===== bench/host_model.sv
// host model driving the register port of the timing configuration block
`timescale 1ns/100ps
module host_model (
  // clock
  input wire logic sys_clk,
  // register port
  output logic wrEn,
  output logic rdEn,
  output logic [3:0] addr,
  output logic [7:0] wrData,
  input wire logic [7:0] rdData,
  input wire logic rdValid
);
  initial begin
    wrEn = 1'b0;
    rdEn = 1'b0;
    addr = 4'h0;
    wrData = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////////////
  // one write strobe, limit field never sent below ten
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    if (a == 4'h4 && d[5:0] < 6'h0a) d[5:0] = 6'h0a;
    @(posedge sys_clk);
    wrEn <= 1'b1;
    addr <= a;
    wrData <= d;
    @(posedge sys_clk);
    wrEn <= 1'b0;
    wrData <= ~d;
  endtask
  // one read strobe, data taken one cycle after it
  task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic v);
    @(posedge sys_clk);
    rdEn <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rdEn <= 1'b0;
    @(posedge sys_clk);
    d = rdData;
    v = rdValid;
  endtask
endmodule

// ===== bench/tb_rf_poll_timing_config.sv
// self-checking bench of the polling timing configuration block
`timescale 1ns/100ps
module tb_rf_poll_timing_config;
  logic sys_clk, rst_n, txMode, sleepStart, edgeIn, wrEn, rdEn, rdValid, vld;
  logic modulation_select, sleepBusy, sleepDone, edgeShort, edgeOk, txBitTick;
  logic dclkTick, xdclkTick, txHalfTick;
  logic [1:0] bitRateRange;
  logic [3:0] addr, check_bit_count;
  logic [7:0] wrData, rdData, rv;
  logic [5:0] limitMin;
  int err_total = 0;
  int samples_checked = 0;
  //////////////////////////////////////////////////////////////////////////////
  rf_poll_timing_config #(.SLEEP_UNIT(2), .DCLK_DIV(8'h01)) dut (.sys_clk(sys_clk),
    .rst_n(rst_n), .wrEn(wrEn), .rdEn(rdEn), .addr(addr), .wrData(wrData),
    .rdData(rdData), .rdValid(rdValid), .txMode(txMode), .bitRateRange(bitRateRange),
    .sleepStart(sleepStart), .edgeIn(edgeIn), .modulation_select(modulation_select),
    .check_bit_count(check_bit_count), .limitMin(limitMin), .sleepBusy(sleepBusy),
    .sleepDone(sleepDone), .dclkTick(dclkTick), .xdclkTick(xdclkTick), .edgeShort(edgeShort),
    .edgeOk(edgeOk), .txHalfTick(txHalfTick), .txBitTick(txBitTick));
  host_model host (.sys_clk(sys_clk), .wrEn(wrEn), .rdEn(rdEn), .addr(addr),
    .wrData(wrData), .rdData(rdData), .rdValid(rdValid));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic stop_test;
    if (err_total == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    host.rd(a, rv, vld);
    chk("rd_valid", 16'h0001, {15'h0, vld});
    chk("rd_data", {8'h00, e}, {8'h00, rv});
  endtask
  // register write with a bit-rate range change on the strobe's edge
  task automatic wr_range(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
    fork
      host.wr(a, d);
      begin
        @(posedge sys_clk);
        bitRateRange <= r;
      end
    join
  endtask
  // sleep length in cycles from start to done
  task automatic sleep_run(input int e);
    int n;
    @(posedge sys_clk);
    sleepStart <= 1'b1;
    @(posedge sys_clk);
    sleepStart <= 1'b0;
    #1;
    n = 1;
    chk("sleep_busy", {15'h0000, e > 1}, {15'h0000, sleepBusy});
    while (sleepDone !== 1'b1 && n < 600) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 600) begin
      err_total++;
      stop_test();
    end
    chk("sleep_cycles", e[15:0], n[15:0]);
  endtask
  // two received edges a given number of cycles apart
  task automatic edge_gap(input int gap, input logic ok);
    @(posedge sys_clk);
    edgeIn <= 1'b1;
    @(posedge sys_clk);
    edgeIn <= 1'b0;
    repeat (gap) @(posedge sys_clk);
    edgeIn <= 1'b1;
    @(posedge sys_clk);
    edgeIn <= 1'b0;
    @(posedge sys_clk);
    chk("edge_ok", {15'h0, ok}, {15'h0, edgeOk});
    chk("edge_short", {15'h0, !ok}, {15'h0, edgeShort});
  endtask
  // cycles, half ticks and scaled ticks between two transmit bit ticks
  task automatic tx_period(input int e, input int xe);
    int n;
    int h;
    int x;
    n = 0;
    h = 0;
    x = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (txBitTick !== 1'b1 && n < 600);
    if (n >= 600) begin
      err_total++;
      stop_test();
    end
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
      if (txHalfTick === 1'b1) h++;
      if (xdclkTick === 1'b1) x++;
    end while (txBitTick !== 1'b1 && n < 600);
    if (n >= 600) begin
      err_total++;
      stop_test();
    end
    chk("tx_bit_cycles", e[15:0], n[15:0]);
    chk("tx_half_ticks", 16'h0002, h[15:0]);
    chk("tx_scaled_ticks", xe[15:0], x[15:0]);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    txMode = 1'b0;
    sleepStart = 1'b0;
    edgeIn = 1'b0;
    bitRateRange = 2'h3;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    chk("mod_rst", 16'h0000, {15'h0, modulation_select});
    chk("chk_rst", 16'h0003, {12'h0, check_bit_count});
    chk("lim_rst", 16'h0010, {10'h0, limitMin});
    chk("dclk_tick", 16'h0001, {15'h0, dclkTick});
    rdchk(4'h3, 8'h28);
    rdchk(4'h4, 8'h50);
    host.wr(4'h5, 8'hff);
    rdchk(4'h0, 8'h00);
    rdchk(4'h3, 8'h28);
    host.wr(4'h3, 8'h80);
    #1;
    chk("mod_ask", 16'h0001, {15'h0, modulation_select});
    rdchk(4'h3, 8'h80);
    for (int c = 0; c < 4; c++) begin
      host.wr(4'h4, {c[1:0], 6'h0a});
      #1;
      chk("chk_count", 16'(3 * c), {12'h0, check_bit_count});
      chk("lim_min", 16'h000a, {10'h0, limitMin});
    end
    host.wr(4'h3, 8'h00);
    sleep_run(1);
    host.wr(4'h3, 8'h88);
    sleep_run(5);
    host.wr(4'h3, 8'h0e);
    sleep_run(49);
    host.wr(4'h3, 8'h00);
    edge_gap(4, 1'b0);
    edge_gap(20, 1'b1);
    wr_range(4'h3, 8'h00, 2'h2);
    edge_gap(12, 1'b0);
    edge_gap(30, 1'b1);
    wr_range(4'h3, 8'h01, 2'h0);
    edge_gap(120, 1'b0);
    edge_gap(200, 1'b1);
    wr_range(4'h3, 8'h00, 2'h3);
    txMode <= 1'b1;
    tx_period(22, 22);
    wr_range(4'h4, 8'h54, 2'h2);
    tx_period(84, 42);
    stop_test();
  end
endmodule
